// ### hdl/dsf_pkg.sv
/*
  Shared constants for the receive frame status and test pattern block:
  register indices, field positions, reset values and detector thresholds.
  Assumes a 100 MHz core clock and a byte-addressed Avalon-MM slave.
*/
package dsf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_TEST_CTRL   = 8'h0C;
  localparam logic [7:0]  IDX_RX_CFG_STAT = 8'h10;
  localparam logic [7:0]  IDX_RX_ALARM    = 8'h11;
  localparam int          ADDR_W          = 12;
  localparam int          IDX_LSB         = 2;
  localparam int          CH_LSB          = 10;

  // Reset values
  localparam logic [7:0]  RST_RX_CFG_STAT = 8'h00;
  localparam logic [7:0]  RST_RX_ALARM    = 8'h00;
  localparam logic [7:0]  RST_TEST_CTRL   = 8'h00;

  // Test register fields
  localparam int          TST_LOCK_BIT    = 4;
  localparam int          TST_CHK_BIT     = 3;
  localparam int          TST_GEN_BIT     = 2;

  // Receive configuration/status fields
  localparam int          CFG_AIS_BIT     = 7;
  localparam int          CFG_LOS_BIT     = 6;
  localparam int          CFG_IDLE_BIT    = 5;
  localparam int          CFG_OOF_BIT     = 4;
  localparam int          CFG_PAR_BIT     = 2;
  localparam int          CFG_FSEL_BIT    = 1;
  localparam int          CFG_MSEL_BIT    = 0;

  // Receive alarm status fields
  localparam int          ST_FERF_BIT     = 4;
  localparam int          ST_AIC_BIT      = 3;
  localparam int          ST_FEBE_LSB     = 0;

  // Loss of signal
  localparam int          LOS_WIN         = 180;
  localparam logic [7:0]  LOS_ZERO_RUN    = 8'hB4;
  localparam logic [7:0]  LOS_ONES_CLR    = 8'h3C;

  // Frame maintenance thresholds
  localparam logic [4:0]  F_ERR_STRICT    = 5'h03;
  localparam logic [4:0]  F_ERR_LOOSE     = 5'h06;
  localparam logic [4:0]  M_ERR_LIMIT     = 5'h03;
  localparam logic [4:0]  P_ERR_LIMIT     = 5'h02;

  // Application identification
  localparam logic [5:0]  AIC_SET_RUN     = 6'h3F;
  localparam logic [4:0]  AIC_CLR_ZEROS   = 5'h02;

  // Pattern generator seed after being found empty
  localparam logic [14:0] PRBS_SEED       = 15'h7FFF;

  // Bus answers
  localparam logic [1:0]  RESP_OK         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // Framer states, Gray coded along search -> verify -> in frame
  typedef enum logic [1:0] {
    FST_SEARCH  = 2'h0,
    FST_VERIFY  = 2'h1,
    FST_INFRAME = 2'h3
  } dsf_fst_e;

endpackage

// ### hdl/dsf_rx_status.sv
/*
  Receive framing control/status and test pattern control for NUM_CH channels.
  Assumes the framer datapath delivers bit and frame strobes already retimed
  to core_clk, and an Avalon-MM master that holds requests under waitrequest.
*/
// How it works
// R01 - Lock flag reads 1 when checker synchronised
// R02 - Software trusts lock only with both enabled
// R03 - Test bit 3 switches checker on/off
// R04 - Test bit 2 switches generator on/off
// R05 - Config bit 7 shows AIS now received
// R06 - Config bit 6 shows loss of signal
// R07 - Config bit 5 shows idle pattern, DS3
// R08 - Config bit 4 shows out of frame
// R09 - Parity bit adds P check at acquisition
// R10 - Parity bit: 2 of 5 P errors reframe
// R11 - F select: 3 or 6 of 16
// R12 - M select set: 3 of 4 errors
// R13 - M select clear: ignore M errors
// R14 - Status bit 4 shows far-end failure
// R15 - AIC sets after 63 consecutive ones
// R16 - AIC clears on 2 zeros in 15
// R17 - Status bits 2:0 hold latest FEBE
// R18 - FEBE 111 clean, 011 errored far end
// R19 - LOS on 180 zeros, clear 60/180 ones
// R20 - Indicators track live; reserved reads zero
// R21 - Each channel has its own copy
`timescale 1ns/100ps

module dsf_rx_status
  import dsf_pkg::*;
#(
  parameter int NUM_CH     = 3,
  parameter int LOCK_MATCH = 32
) (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_b,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0]   avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  output logic      [1:0]          avs_response,
  // Line bit stream from the framer datapath
  input  wire logic [NUM_CH-1:0]   rx_bit_en,
  input  wire logic [NUM_CH-1:0]   rx_bit,
  input  wire logic [NUM_CH-1:0]   tx_bit_en,
  // Overhead events from the framer datapath
  input  wire logic [NUM_CH-1:0]   frame_cand,
  input  wire logic [NUM_CH-1:0]   fbit_en,
  input  wire logic [NUM_CH-1:0]   fbit_err,
  input  wire logic [NUM_CH-1:0]   mbit_en,
  input  wire logic [NUM_CH-1:0]   mbit_err,
  input  wire logic [NUM_CH-1:0]   frame_end,
  input  wire logic [NUM_CH-1:0]   pbit_err,
  input  wire logic [NUM_CH-1:0]   aic_bit,
  input  wire logic [3*NUM_CH-1:0] febe_bits,
  // Condition detectors from the framer datapath
  input  wire logic [NUM_CH-1:0]   ais_det,
  input  wire logic [NUM_CH-1:0]   idle_det,
  input  wire logic [NUM_CH-1:0]   ferf_det,
  // Outputs to the datapath
  output logic      [NUM_CH-1:0]   out_of_frame_flag,
  output logic      [NUM_CH-1:0]   signal_loss_flag,
  output logic      [NUM_CH-1:0]   pattern_generator_on,
  output logic      [NUM_CH-1:0]   pattern_checker_on,
  output logic      [NUM_CH-1:0]   pattern_checker_locked,
  output logic      [NUM_CH-1:0]   prbs_tx_bit
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  if (NUM_CH < 1 || NUM_CH > 4) begin : g_bad_ch
    $error("NUM_CH must be 1 to 4");
  end
  if (LOCK_MATCH < 2 || LOCK_MATCH > 63) begin : g_bad_lock
    $error("LOCK_MATCH must be 2 to 63");
  end

  localparam logic [5:0] LOCK_N = 6'(LOCK_MATCH);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic               par_req;
    logic               fbit_maint_select;
    logic               mbit_maint_select;
    logic               chk_on;
    logic               gen_on;
    logic               locked;
    logic               los;
    logic [7:0]         zero_run;
    logic [7:0]         ones_cnt;
    logic [LOS_WIN-1:0] bit_hist;
    dsf_fst_e           fst;
    logic [15:0]        f_hist;
    logic [3:0]         m_hist;
    logic [4:0]         p_hist;
    logic               aic;
    logic [5:0]         aic_run;
    logic [14:0]        aic_zero_hist;
    logic [2:0]         febe;
    logic               ais;
    logic               idle;
    logic               ferf;
    logic [14:0]        gen_lfsr;
    logic               gen_bit;
    logic [14:0]        chk_sh;
    logic [5:0]         match_cnt;
  } dsf_ch_s;

  typedef struct packed {
    dsf_ch_s [NUM_CH-1:0] ch;
    logic                 wait_n;
    logic [31:0]          rdata;
    logic [1:0]           resp;
  } dsf_state_s;

  dsf_state_s state_ff;
  dsf_state_s nxt_state;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Ones in a window of up to sixteen events
  function automatic logic [4:0] dsf_pop16(input logic [15:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < 16; i++) begin
      n = n + {4'h0, v[i]};
    end
    return n;
  endfunction

  // Per-channel register image; reserved bits are zero
  function automatic logic [7:0] dsf_reg_img(input dsf_ch_s c, input logic [7:0] idx,
                                             output logic hit);
    logic [7:0] v;
    v   = 8'h00;
    hit = 1'b1;
    if (idx == IDX_TEST_CTRL) begin
      v[TST_LOCK_BIT] = c.locked;                                    // R01
      v[TST_CHK_BIT]  = c.chk_on;
      v[TST_GEN_BIT]  = c.gen_on;
    end else if (idx == IDX_RX_CFG_STAT) begin
      v[CFG_AIS_BIT]  = c.ais;                                       // R05
      v[CFG_LOS_BIT]  = c.los;                                       // R06
      v[CFG_IDLE_BIT] = c.idle;                                      // R07
      v[CFG_OOF_BIT]  = (c.fst != FST_INFRAME);                      // R08
      v[CFG_PAR_BIT]  = c.par_req;
      v[CFG_FSEL_BIT] = c.fbit_maint_select;
      v[CFG_MSEL_BIT] = c.mbit_maint_select;
    end else if (idx == IDX_RX_ALARM) begin
      v[ST_FERF_BIT]  = c.ferf;                                      // R14
      v[ST_AIC_BIT]   = c.aic;
      v[ST_FEBE_LSB +: 3] = c.febe;                                  // R17
    end else begin
      hit = 1'b0;
    end
    return v;                                                        // R20
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    dsf_ch_s     c;
    logic [7:0]  idx;
    logic [1:0]  chn;
    logic        hit;
    logic [7:0]  img;
    logic [7:0]  ones_n;
    logic [15:0] f_n;
    logic [3:0]  m_n;
    logic [4:0]  p_n;
    logic [14:0] z_n;
    logic [4:0]  f_lim;
    logic        lose;
    logic        pred;
    c         = '0;
    idx       = avs_address[IDX_LSB +: 8];
    chn       = avs_address[CH_LSB +: 2];
    hit       = 1'b0;
    img       = 8'h00;
    ones_n    = 8'h00;
    f_n       = 16'h0000;
    m_n       = 4'h0;
    p_n       = 5'h00;
    z_n       = 15'h0000;
    f_lim     = 5'h00;
    lose      = 1'b0;
    pred      = 1'b0;
    nxt_state = state_ff;

    for (int k = 0; k < NUM_CH; k++) begin                           // R21
      c = state_ff.ch[k];

      // Live condition indicators
      c.ais  = ais_det[k];                                           // R05
      c.idle = idle_det[k];                                          // R07
      c.ferf = ferf_det[k];                                          // R14

      // Loss of signal over a sliding window of line bits
      if (rx_bit_en[k]) begin
        ones_n     = c.ones_cnt + {7'h00, rx_bit[k]} - {7'h00, c.bit_hist[LOS_WIN-1]};
        c.ones_cnt = ones_n;
        c.bit_hist = {c.bit_hist[LOS_WIN-2:0], rx_bit[k]};
        if (rx_bit[k]) begin
          c.zero_run = 8'h00;
        end else if (c.zero_run != LOS_ZERO_RUN) begin
          c.zero_run = c.zero_run + 8'h01;
        end
        if (c.zero_run == LOS_ZERO_RUN) begin
          c.los = 1'b1;                                              // R19
        end else if (c.los && ones_n >= LOS_ONES_CLR) begin
          c.los = 1'b0;                                              // R19
        end
      end

      // Far-end block error code of the latest frame
      if (frame_end[k]) begin
        c.febe = febe_bits[3*k +: 3];                                // R17 R18
      end

      // Application identification
      if (frame_end[k]) begin
        z_n             = {c.aic_zero_hist[13:0], ~aic_bit[k]};
        c.aic_zero_hist = z_n;
        c.aic_run       = !aic_bit[k] ? 6'h00 :
                          (c.aic_run == AIC_SET_RUN) ? c.aic_run : c.aic_run + 6'h01;
        if (dsf_pop16({1'b0, z_n}) >= AIC_CLR_ZEROS) begin
          c.aic = 1'b0;                                              // R16
        end
        if (c.aic_run == AIC_SET_RUN) begin
          c.aic = 1'b1;                                              // R15
        end
      end

      // Frame search, verification and maintenance
      f_n   = c.f_hist;
      m_n   = c.m_hist;
      p_n   = c.p_hist;
      f_lim = c.fbit_maint_select ? F_ERR_STRICT : F_ERR_LOOSE;      // R11
      lose  = 1'b0;
      case (c.fst)
        FST_SEARCH: begin
          if (frame_cand[k]) begin
            c.fst = FST_VERIFY;
          end
        end
        FST_VERIFY: begin
          if (frame_end[k]) begin
            c.fst = (c.par_req && pbit_err[k]) ? FST_SEARCH : FST_INFRAME; // R09
          end
        end
        FST_INFRAME: begin
          if (fbit_en[k]) begin
            f_n = {c.f_hist[14:0], fbit_err[k]};
          end
          if (mbit_en[k] && c.mbit_maint_select) begin
            m_n = {c.m_hist[2:0], mbit_err[k]};                      // R13
          end
          if (frame_end[k] && c.par_req) begin
            p_n = {c.p_hist[3:0], pbit_err[k]};
          end
          lose = (dsf_pop16(f_n) >= f_lim)                           // R11
               | (c.mbit_maint_select && dsf_pop16({12'h000, m_n}) >= M_ERR_LIMIT) // R12
               | (c.par_req && dsf_pop16({11'h000, p_n}) >= P_ERR_LIMIT); // R10
          if (lose) begin
            c.fst = FST_SEARCH;
          end
        end
        default: begin
          c.fst = FST_SEARCH;
        end
      endcase
      // Windows restart whenever frame is not held
      if (lose || c.fst != FST_INFRAME) begin
        f_n = 16'h0000;
        m_n = 4'h0;
        p_n = 5'h00;
      end
      c.f_hist = f_n;
      c.m_hist = m_n;
      c.p_hist = p_n;

      // Pattern generator, PRBS15
      if (!c.gen_on) begin
        c.gen_bit = 1'b0;                                            // R04
      end else if (c.gen_lfsr == 15'h0000) begin
        c.gen_lfsr = PRBS_SEED;
      end else if (tx_bit_en[k]) begin
        c.gen_bit  = c.gen_lfsr[14] ^ c.gen_lfsr[13];
        c.gen_lfsr = {c.gen_lfsr[13:0], c.gen_lfsr[14] ^ c.gen_lfsr[13]};
      end

      // Self-synchronising checker; one mismatch drops lock
      if (!c.chk_on) begin
        c.locked    = 1'b0;                                          // R03
        c.match_cnt = 6'h00;
      end else if (rx_bit_en[k]) begin
        pred     = c.chk_sh[14] ^ c.chk_sh[13];
        c.chk_sh = {c.chk_sh[13:0], rx_bit[k]};
        if (rx_bit[k] == pred && c.chk_sh != 15'h0000) begin
          if (c.match_cnt != LOCK_N) begin
            c.match_cnt = c.match_cnt + 6'h01;
          end
          c.locked = (c.match_cnt == LOCK_N);                        // R01 R02
        end else begin
          c.match_cnt = 6'h00;
          c.locked    = 1'b0;
        end
      end

      // Register writes land in the cycle waitrequest is low
      if (avs_write && state_ff.wait_n && avs_byteenable[0] && 32'(chn) == k) begin
        if (idx == IDX_TEST_CTRL) begin
          c.chk_on = avs_writedata[TST_CHK_BIT];                     // R03
          c.gen_on = avs_writedata[TST_GEN_BIT];                     // R04
        end else if (idx == IDX_RX_CFG_STAT) begin
          c.par_req           = avs_writedata[CFG_PAR_BIT];          // R09
          c.fbit_maint_select = avs_writedata[CFG_FSEL_BIT];         // R11
          c.mbit_maint_select = avs_writedata[CFG_MSEL_BIT];         // R12
        end
      end
      nxt_state.ch[k] = c;
    end

    // Bus slave: one wait cycle, then accept; read data captured meanwhile
    if ((avs_read || avs_write) && !state_ff.wait_n) begin
      nxt_state.wait_n = 1'b1;
      img = 8'h00;
      hit = 1'b0;
      for (int k = 0; k < NUM_CH; k++) begin
        if (32'(chn) == k) begin
          img = dsf_reg_img(state_ff.ch[k], idx, hit);
        end
      end
      nxt_state.rdata = avs_read ? {24'h000000, img} : 32'h00000000;
      nxt_state.resp  = hit ? RESP_OK : RESP_SLVERR;
    end else begin
      nxt_state.wait_n = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers; reset clears every field, yet the receive config/status register then reads 8'h10 (out of frame), not RST_RX_CFG_STAT
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs from flip-flops; waitrequest inverted and out_of_frame_flag decoded from the framer state
  assign avs_readdata    = state_ff.rdata;
  assign avs_waitrequest = !state_ff.wait_n;
  assign avs_response    = state_ff.resp;

  for (genvar k = 0; k < NUM_CH; k++) begin : g_out
    assign out_of_frame_flag[k]      = state_ff.ch[k].fst != FST_INFRAME;   // R08
    assign signal_loss_flag[k]       = state_ff.ch[k].los;
    assign pattern_generator_on[k]   = state_ff.ch[k].gen_on;
    assign pattern_checker_on[k]     = state_ff.ch[k].chk_on;
    assign pattern_checker_locked[k] = state_ff.ch[k].locked;
    assign prbs_tx_bit[k]            = state_ff.ch[k].gen_bit;
  end

endmodule

// ### testbench/dsf_line_model.sv
/*
  Line side model: one received bit and one generator step per clock.
  Assumes mode 0 sends zeros, 1 sends ones, 2 loops the generator back.
*/
`timescale 1ns/100ps
module dsf_line_model #(
  parameter int NUM_CH = 3
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  // Control and loopback
  input  wire logic [1:0]        mode,
  input  wire logic [NUM_CH-1:0] prbs_tx_bit,
  // Line stream
  output logic      [NUM_CH-1:0] rx_bit_en,
  output logic      [NUM_CH-1:0] rx_bit,
  output logic      [NUM_CH-1:0] tx_bit_en
);
  // A bit every cycle stresses the detectors harder than a real line rate
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_bit_en <= '0;
      tx_bit_en <= '0;
      rx_bit    <= '0;
    end else begin
      rx_bit_en <= '1;
      tx_bit_en <= '1;
      case (mode)
        2'h0:    rx_bit <= '0;
        2'h1:    rx_bit <= '1;
        default: rx_bit <= prbs_tx_bit;
      endcase
    end
  end
endmodule

// ### testbench/dsf_rx_status_asserts.sv
/*
  Checker for the receive status block: bus timing, enables, frame flags.
  Assumes it is bound to every instance of the top module.
*/
`timescale 1ns/100ps
module dsf_rx_status_asserts
  import dsf_pkg::*;
#(
  parameter int NUM_CH = 3
) (
  // Clock and reset
  input wire logic                core_clk,
  input wire logic                rst_b,
  // Bus
  input wire logic [ADDR_W-1:0]   avs_address,
  input wire logic                avs_read,
  input wire logic                avs_write,
  input wire logic [31:0]         avs_writedata,
  input wire logic [3:0]          avs_byteenable,
  input wire logic [31:0]         avs_readdata,
  input wire logic                avs_waitrequest,
  input wire logic [1:0]          avs_response,
  // Datapath
  input wire logic [NUM_CH-1:0]   rx_bit_en,
  input wire logic [NUM_CH-1:0]   fbit_en,
  input wire logic [NUM_CH-1:0]   mbit_en,
  input wire logic [NUM_CH-1:0]   frame_end,
  input wire logic [NUM_CH-1:0]   out_of_frame_flag,
  input wire logic [NUM_CH-1:0]   signal_loss_flag,
  input wire logic [NUM_CH-1:0]   pattern_generator_on,
  input wire logic [NUM_CH-1:0]   pattern_checker_on,
  input wire logic [NUM_CH-1:0]   pattern_checker_locked
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] idx;
  logic [1:0] ch;
  logic       acc;
  logic       hit;
  logic       wr_tst;
  assign idx    = avs_address[9:2];
  assign ch     = avs_address[11:10];
  assign acc    = !avs_waitrequest && (avs_read || avs_write);
  assign hit    = (idx == IDX_TEST_CTRL || idx == IDX_RX_CFG_STAT || idx == IDX_RX_ALARM)
                  && ({30'h0, ch} < NUM_CH);
  assign wr_tst = acc && avs_write && idx == IDX_TEST_CTRL && ch == 2'h0 && avs_byteenable[0];
  ////////////////////////////////////////////////////////////////////////////
  a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("waitrequest not low after one wait cycle");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low for two cycles");
  a_unmapped_resp: assert property (acc && avs_read && !hit |-> avs_response == RESP_SLVERR && avs_readdata == 32'h0) else $error("unmapped read answered wrongly");
  a_mapped_ok: assert property (acc && hit |-> avs_response == RESP_OK) else $error("mapped access refused");
  a_upper_zero: assert property (acc && avs_read |-> avs_readdata[31:8] == 24'h0) else $error("upper read bits not zero");
  a_gen_enable: assert property (wr_tst |=> pattern_generator_on[0] == $past(avs_writedata[TST_GEN_BIT])) else $error("generator enable not taken");
  a_chk_enable: assert property (wr_tst |=> pattern_checker_on[0] == $past(avs_writedata[TST_CHK_BIT])) else $error("checker enable not taken");
  a_oof_clear: assert property ($fell(out_of_frame_flag[0]) |-> $past(frame_end[0])) else $error("frame flag cleared without frame end");
  a_oof_cause: assert property ($rose(out_of_frame_flag[0]) |-> $past(fbit_en[0] || mbit_en[0] || frame_end[0])) else $error("frame flag set without event");
  a_los_on_bit: assert property ($changed(signal_loss_flag[0]) |-> $past(rx_bit_en[0])) else $error("loss flag moved without a bit");
  a_lock_needs_chk: assert property (pattern_checker_locked[0] |-> $past(pattern_checker_on[0])) else $error("lock with checker off");
endmodule

bind dsf_rx_status dsf_rx_status_asserts #(.NUM_CH(NUM_CH)) u_chk (
  .core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response(avs_response), .rx_bit_en(rx_bit_en), .fbit_en(fbit_en),
  .mbit_en(mbit_en), .frame_end(frame_end), .out_of_frame_flag(out_of_frame_flag),
  .signal_loss_flag(signal_loss_flag), .pattern_generator_on(pattern_generator_on),
  .pattern_checker_on(pattern_checker_on), .pattern_checker_locked(pattern_checker_locked));

// ### testbench/dsf_rx_status_tb_top.sv
/*
  Bench for the receive status block: registers, framing, alarms, pattern test.
  Assumes the line model above and a bound checker.
*/
`timescale 1ns/100ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin failures++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end
module dsf_rx_status_tb_top;
  import dsf_pkg::*;
  logic core_clk, rst_b, avs_read, avs_write, avs_waitrequest;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [1:0] avs_response, mode;
  logic [2:0] rx_bit_en, rx_bit, tx_bit_en, frame_cand, fbit_en, fbit_err, mbit_en;
  logic [2:0] mbit_err, frame_end, pbit_err, aic_bit, ais_det, idle_det, ferf_det;
  logic [2:0] oof, los, gen_on, chk_on, lock, prbs_tx_bit;
  logic [8:0] febe_bits;
  logic [7:0] q;
  logic [1:0] r;
  int failures, total_checks, cyc;
  dsf_rx_status dut (.core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .rx_bit_en(rx_bit_en),
    .rx_bit(rx_bit), .tx_bit_en(tx_bit_en), .frame_cand(frame_cand), .fbit_en(fbit_en),
    .fbit_err(fbit_err), .mbit_en(mbit_en), .mbit_err(mbit_err), .frame_end(frame_end),
    .pbit_err(pbit_err), .aic_bit(aic_bit), .febe_bits(febe_bits), .ais_det(ais_det),
    .idle_det(idle_det), .ferf_det(ferf_det), .out_of_frame_flag(oof),
    .signal_loss_flag(los), .pattern_generator_on(gen_on), .pattern_checker_on(chk_on),
    .pattern_checker_locked(lock), .prbs_tx_bit(prbs_tx_bit));
  dsf_line_model u_line (.core_clk(core_clk), .rst_b(rst_b), .mode(mode),
    .prbs_tx_bit(prbs_tx_bit), .rx_bit_en(rx_bit_en), .rx_bit(rx_bit), .tx_bit_en(tx_bit_en));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic results();
    if (failures == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Ceiling well above the fewer than a thousand cycles the run needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end
  task automatic bus(input logic w, input logic [1:0] c, input logic [7:0] i,
                     input logic [7:0] d);
    @(posedge core_clk);
    avs_address <= {c, i, 2'b00};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    r = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] c, input logic [7:0] i, input logic [7:0] e);
    bus(1'b0, c, i, 8'h00);
    `CHK("readdata", e, q)
  endtask
  // One-cycle strobe then one idle cycle, so no edge sees two events merged
  task automatic ev(input int k);
    @(posedge core_clk);
    frame_cand[0] <= (k == 0);
    fbit_en[0] <= (k == 1 || k == 2);
    fbit_err[0] <= (k == 2);
    mbit_en[0] <= (k == 3);
    mbit_err[0] <= (k == 3);
    frame_end[0] <= (k >= 4);
    pbit_err[0] <= (k == 5);
    @(posedge core_clk);
    {frame_cand, fbit_en, fbit_err, mbit_en, mbit_err, frame_end, pbit_err} <= '0;
  endtask
  task automatic f_chk(input logic e);
    @(negedge core_clk);
    `CHK("out_of_frame_flag", e, oof[0])
  endtask
  task automatic evn(input int k, input int n);
    for (int i = 0; i < n; i++) ev(k);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(2'h0, IDX_RX_CFG_STAT, 8'h10);
    rd(2'h0, IDX_RX_ALARM, RST_RX_ALARM);
    rd(2'h0, IDX_TEST_CTRL, RST_TEST_CTRL);
    bus(1'b1, 2'h0, IDX_RX_CFG_STAT, 8'hFF);
    rd(2'h0, IDX_RX_CFG_STAT, 8'h17);
    rd(2'h1, IDX_RX_CFG_STAT, 8'h10);
    bus(1'b0, 2'h3, IDX_RX_CFG_STAT, 8'h00);
    `CHK("response", RESP_SLVERR, r)
    rd(2'h0, 8'h20, 8'h00);
    bus(1'b1, 2'h0, IDX_TEST_CTRL, 8'hFF);
    rd(2'h0, IDX_TEST_CTRL, 8'h0C);
    `CHK("engines", 2'b11, {gen_on[0], chk_on[0]})
  endtask
  task automatic t_prbs();
    mode <= 2'h2;
    repeat (200) @(posedge core_clk);
    rd(2'h0, IDX_TEST_CTRL, 8'h1C);
    bus(1'b1, 2'h0, IDX_TEST_CTRL, 8'h00);
    rd(2'h0, IDX_TEST_CTRL, 8'h00);
    mode <= 2'h1;
  endtask
  task automatic t_frame();
    bus(1'b1, 2'h0, IDX_RX_CFG_STAT, 8'h00);
    ev(0); ev(4); f_chk(1'b0);
    evn(3, 4); f_chk(1'b0);
    evn(2, 5); evn(1, 10); f_chk(1'b0); ev(2); f_chk(1'b1);
    bus(1'b1, 2'h0, IDX_RX_CFG_STAT, 8'h02);
    ev(0); ev(4); evn(2, 2); f_chk(1'b0); ev(2); f_chk(1'b1);
    bus(1'b1, 2'h0, IDX_RX_CFG_STAT, 8'h01);
    ev(0); ev(4); evn(3, 2); f_chk(1'b0); ev(3); f_chk(1'b1);
    bus(1'b1, 2'h0, IDX_RX_CFG_STAT, 8'h04);
    ev(0); ev(5); f_chk(1'b1);
    ev(0); ev(4); ev(5); f_chk(1'b0); ev(5); f_chk(1'b1);
  endtask
  task automatic t_status();
    bus(1'b1, 2'h0, IDX_RX_CFG_STAT, 8'h00);
    ais_det <= 3'b001;
    idle_det <= 3'b001;
    ferf_det <= 3'b001;
    rd(2'h0, IDX_RX_CFG_STAT, 8'hB0);
    rd(2'h0, IDX_RX_ALARM, 8'h10);
    rd(2'h1, IDX_RX_ALARM, 8'h00);
    {ais_det, idle_det, ferf_det} <= '0;
    ev(0); ev(4);
    febe_bits <= 9'h007;
    ev(4); rd(2'h0, IDX_RX_ALARM, 8'h07);
    febe_bits <= 9'h003;
    aic_bit <= 3'b001;
    evn(4, 62); rd(2'h0, IDX_RX_ALARM, 8'h03);
    evn(4, 1); rd(2'h0, IDX_RX_ALARM, 8'h0B);
    aic_bit <= 3'b000;
    ev(4); rd(2'h0, IDX_RX_ALARM, 8'h0B);
    ev(4); rd(2'h0, IDX_RX_ALARM, 8'h03);
  endtask
  task automatic t_los();
    mode <= 2'h0;
    repeat (181) @(negedge core_clk);
    `CHK("signal_loss_flag", 1'b0, los[0])
    repeat (1) @(negedge core_clk);
    `CHK("signal_loss_flag", 1'b1, los[0])
    rd(2'h0, IDX_RX_CFG_STAT, 8'h40);
    mode <= 2'h1;
    repeat (61) @(negedge core_clk);
    `CHK("signal_loss_flag", 1'b1, los[0])
    repeat (1) @(negedge core_clk);
    `CHK("signal_loss_flag", 1'b0, los[0])
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_b, avs_read, avs_write, frame_cand, fbit_en, fbit_err, mbit_en, mbit_err} = '0;
    {frame_end, pbit_err, aic_bit, ais_det, idle_det, ferf_det, febe_bits} = '0;
    avs_address = '0;
    avs_writedata = '0;
    avs_byteenable = 4'h1;
    mode = 2'h1;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    t_regs();
    t_prbs();
    t_frame();
    t_status();
    t_los();
    results();
  end
endmodule
